// ### design/emitter_power_sample_regs.v
// register bank of the optical front-end: emitter drive codes, power
// and clock controls, fault pin routing and the four sample results.
// assumes the host port, converter and timing inputs all run on clk_sys.
// Summary of operation
// - drive disable bit switches current source off
// - emitter a code in bits 15:8
// - emitter b code in bits 7:0
// - topology bit: zero h-bridge, one push-pull
// - float bit releases all digital outputs
// - crystal disable selects external oscillator input
// - transmit powerdown stops transmit section only
// - receive powerdown stops receive section only
// - frontend powerdown stops every section
// - route bit low: fault pins show alarms
// - route bit high: fault pins show timing
// - emitter b sample stored, ready strobe
// - emitter b ambient stored, ready strobe
// - emitter a sample stored, ready strobe
// - emitter a ambient stored, ready strobe
// - select code picks timing signal pair
`timescale 1ns/1ps
`include "emitter_power_sample_regs_defines.vh"

module emitter_power_sample_regs
#(
  parameter FACTORY_A_VALUE = 24'h5a5a5a, // arbitrary factory pattern
  parameter FACTORY_B_VALUE = 24'ha5a5a5  // arbitrary factory pattern
)
(
  input wire clk_sys,
  input wire reset,
  // host register port
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`DATA_W-1:0] reg_rdata,
  // converter results
  input wire sample_valid,
  input wire [1:0] sample_sel,
  input wire [`SAMPLE_W-1:0] sample_data,
  output reg conversion_ready_strobe,
  // internal timing pulses, one bit per select code 0 to 4
  input wire [4:0] timing_b,
  input wire [4:0] timing_a,
  // diagnostic alarms
  input wire photodiode_alarm,
  input wire emitter_alarm,
  // emitter driver
  output reg led_drive_disable,
  output reg [7:0] emitter_a_current,
  output reg [7:0] emitter_b_current,
  output reg driver_topology_select,
  // oscillator and power
  output reg crystal_osc_enable,
  output reg transmit_power_on,
  output reg receive_power_on,
  output reg diagnostic_power_on,
  // digital output pins
  output reg photodiode_fault_pin_out,
  output reg photodiode_fault_pin_oe,
  output reg emitter_fault_pin_out,
  output reg emitter_fault_pin_oe,
  output reg serial_data_out_oe,
  output reg clock_out_oe
);

  // control registers
  reg [`DATA_W-1:0] emitter_current_control_reg;
  reg [`DATA_W-1:0] drive_clock_power_control_reg;
  reg [`DATA_W-1:0] clock_control_reg;
  reg [`DATA_W-1:0] fault_pin_function_reg;
  // sample registers
  reg [`SAMPLE_W-1:0] emitter_b_sample_reg;
  reg [`SAMPLE_W-1:0] emitter_b_ambient_sample_reg;
  reg [`SAMPLE_W-1:0] emitter_a_sample_reg;
  reg [`SAMPLE_W-1:0] emitter_a_ambient_sample_reg;
  // decoded fields
  wire [2:0] fault_pin_clock_select;
  wire fault_pin_clock_route_enable;
  wire output_float_enable;
  wire transmit_powerdown;
  wire receive_powerdown;
  wire frontend_powerdown;
  wire sample_take;
  reg [`DATA_W-1:0] read_next;
  reg pd_fault_next;
  reg em_fault_next;

  // write mask keeps only the writable field bits of each register
  function [`DATA_W-1:0] mask_write;
    input [`DATA_W-1:0] data;
    input [`DATA_W-1:0] keep;
    begin
      mask_write = data & keep;
    end
  endfunction

  // pick one timing bit, codes above the last one give a quiet pin
  function pick_timing;
    input [4:0] pulses;
    input [2:0] code;
    begin
      if (code > `CLK_SEL_LAST)
      begin
        pick_timing = 1'b0;
      end
      else
      begin
        pick_timing = pulses[code];
      end
    end
  endfunction

  assign fault_pin_clock_select =
    clock_control_reg[`MSB_FAULT_CLOCK_SELECT:`LSB_FAULT_CLOCK_SELECT];
  assign fault_pin_clock_route_enable =
    fault_pin_function_reg[`BIT_FAULT_CLOCK_ROUTE];
  assign output_float_enable =
    drive_clock_power_control_reg[`BIT_OUTPUT_FLOAT];
  assign transmit_powerdown =
    drive_clock_power_control_reg[`BIT_TX_POWERDOWN];
  assign receive_powerdown =
    drive_clock_power_control_reg[`BIT_RX_POWERDOWN];
  assign frontend_powerdown =
    drive_clock_power_control_reg[`BIT_FRONTEND_POWERDOWN];

  // a powered-down receiver converts nothing, so results are dropped
  assign sample_take = sample_valid & ~receive_powerdown & ~frontend_powerdown;

  // control register writes, fixed and reserved bits are never stored
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      emitter_current_control_reg <= `RESET_CONTROL;
      drive_clock_power_control_reg <= `RESET_CONTROL;
      clock_control_reg <= `RESET_CONTROL;
      fault_pin_function_reg <= `RESET_CONTROL;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `OFS_EMITTER_CURRENT:
        begin
          emitter_current_control_reg <=
            mask_write(reg_wdata, 24'h02ffff);
        end
        `OFS_DRIVE_CLOCK_POWER:
        begin
          drive_clock_power_control_reg <=
            mask_write(reg_wdata, 24'h000e07);
        end
        `OFS_CLOCK_CONTROL:
        begin
          clock_control_reg <= mask_write(reg_wdata, 24'h000e00);
        end
        `OFS_FAULT_PIN:
        begin
          fault_pin_function_reg <= mask_write(reg_wdata, 24'h000080);
        end
        default:
        begin
          // spares, factory slots and samples ignore writes
          emitter_current_control_reg <= emitter_current_control_reg;
        end
      endcase
    end
  end

  // sample capture, one result register per selector code
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      emitter_b_sample_reg <= `RESET_SAMPLE;
      emitter_b_ambient_sample_reg <= `RESET_SAMPLE;
      emitter_a_sample_reg <= `RESET_SAMPLE;
      emitter_a_ambient_sample_reg <= `RESET_SAMPLE;
    end
    else if (sample_take)
    begin
      case (sample_sel)
        `SEL_EMITTER_B:
        begin
          emitter_b_sample_reg <= sample_data;
        end
        `SEL_EMITTER_B_AMBIENT:
        begin
          emitter_b_ambient_sample_reg <= sample_data;
        end
        `SEL_EMITTER_A:
        begin
          emitter_a_sample_reg <= sample_data;
        end
        default:
        begin
          emitter_a_ambient_sample_reg <= sample_data;
        end
      endcase
    end
  end

  // ready strobe marks the cycle the new value becomes readable
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      conversion_ready_strobe <= 1'b0;
    end
    else
    begin
      conversion_ready_strobe <= sample_take;
    end
  end

  // read mux, fixed bits always read back at their constant values
  always @*
  begin
    read_next = {`DATA_W{1'b0}};
    case (reg_addr)
      `OFS_CLOCK_CONTROL:
      begin
        read_next = clock_control_reg | `FIXED_CLOCK_CONTROL;
      end
      `OFS_EMITTER_CURRENT:
      begin
        read_next = emitter_current_control_reg | `FIXED_EMITTER_CURRENT;
      end
      `OFS_DRIVE_CLOCK_POWER:
      begin
        read_next = drive_clock_power_control_reg | `FIXED_DRIVE_CLOCK_POWER;
      end
      `OFS_SPARE_B, `OFS_SPARE_C, `OFS_SPARE_D:
      begin
        read_next = {`DATA_W{1'b0}};
      end
      `OFS_FACTORY_A:
      begin
        read_next = FACTORY_A_VALUE;
      end
      `OFS_FACTORY_B:
      begin
        read_next = FACTORY_B_VALUE;
      end
      `OFS_FAULT_PIN:
      begin
        read_next = fault_pin_function_reg;
      end
      `OFS_EMITTER_B_SAMPLE:
      begin
        read_next = emitter_b_sample_reg;
      end
      `OFS_EMITTER_B_AMBIENT:
      begin
        read_next = emitter_b_ambient_sample_reg;
      end
      `OFS_EMITTER_A_SAMPLE:
      begin
        read_next = emitter_a_sample_reg;
      end
      `OFS_EMITTER_A_AMBIENT:
      begin
        read_next = emitter_a_ambient_sample_reg;
      end
      default:
      begin
        // unmapped offsets read as zero
        read_next = {`DATA_W{1'b0}};
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      reg_rdata <= {`DATA_W{1'b0}};
    end
    else if (reg_read)
    begin
      reg_rdata <= read_next;
    end
    else
    begin
      reg_rdata <= {`DATA_W{1'b0}};
    end
  end

  // fault pin source: alarms by default, timing pulses when routed
  always @*
  begin
    pd_fault_next = photodiode_alarm;
    em_fault_next = emitter_alarm;
    if (fault_pin_clock_route_enable)
    begin
      pd_fault_next = pick_timing(timing_b, fault_pin_clock_select);
      em_fault_next = pick_timing(timing_a, fault_pin_clock_select);
    end
  end

  // emitter driver outputs, registered to keep the pins glitch free
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      led_drive_disable <= 1'b0;
      emitter_a_current <= 8'h00;
      emitter_b_current <= 8'h00;
      driver_topology_select <= 1'b0;
    end
    else
    begin
      led_drive_disable <=
        emitter_current_control_reg[`BIT_LED_DRIVE_DISABLE];
      emitter_a_current <= emitter_current_control_reg
        [`MSB_EMITTER_A_CURRENT:`LSB_EMITTER_A_CURRENT];
      emitter_b_current <= emitter_current_control_reg
        [`MSB_EMITTER_B_CURRENT:`LSB_EMITTER_B_CURRENT];
      driver_topology_select <=
        drive_clock_power_control_reg[`BIT_DRIVER_TOPOLOGY];
    end
  end

  // oscillator and section power enables
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      crystal_osc_enable <= 1'b1;
      transmit_power_on <= 1'b1;
      receive_power_on <= 1'b1;
      diagnostic_power_on <= 1'b1;
    end
    else
    begin
      crystal_osc_enable <=
        ~drive_clock_power_control_reg[`BIT_CRYSTAL_DISABLE];
      transmit_power_on <= ~transmit_powerdown & ~frontend_powerdown;
      receive_power_on <= ~receive_powerdown & ~frontend_powerdown;
      diagnostic_power_on <= ~frontend_powerdown;
    end
  end

  // digital pin drivers, the float bit releases every one of them
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      photodiode_fault_pin_out <= 1'b0;
      emitter_fault_pin_out <= 1'b0;
      photodiode_fault_pin_oe <= 1'b1;
      emitter_fault_pin_oe <= 1'b1;
      serial_data_out_oe <= 1'b1;
      clock_out_oe <= 1'b1;
    end
    else
    begin
      photodiode_fault_pin_out <= pd_fault_next;
      emitter_fault_pin_out <= em_fault_next;
      photodiode_fault_pin_oe <= ~output_float_enable;
      emitter_fault_pin_oe <= ~output_float_enable;
      serial_data_out_oe <= ~output_float_enable;
      clock_out_oe <= ~output_float_enable;
    end
  end

endmodule // emitter_power_sample_regs

// ### design/emitter_power_sample_regs_defines.vh
// register offsets, field positions and fixed bits of the emitter,
// power and sample register bank.
// assumes a 24-bit register word behind a plain address port.
`ifndef EMITTER_POWER_SAMPLE_REGS_DEFINES_VH
`define EMITTER_POWER_SAMPLE_REGS_DEFINES_VH

`define ADDR_W 8
`define DATA_W 24
`define SAMPLE_W 24

// register offsets
`define OFS_CLOCK_CONTROL 8'h1e
`define OFS_EMITTER_CURRENT 8'h22
`define OFS_DRIVE_CLOCK_POWER 8'h23
`define OFS_SPARE_B 8'h24
`define OFS_SPARE_C 8'h25
`define OFS_SPARE_D 8'h26
`define OFS_FACTORY_A 8'h27
`define OFS_FACTORY_B 8'h28
`define OFS_FAULT_PIN 8'h29
`define OFS_EMITTER_B_SAMPLE 8'h2a
`define OFS_EMITTER_B_AMBIENT 8'h2b
`define OFS_EMITTER_A_SAMPLE 8'h2c
`define OFS_EMITTER_A_AMBIENT 8'h2d

// emitter current control fields
`define BIT_LED_DRIVE_DISABLE 17
`define MSB_EMITTER_A_CURRENT 15
`define LSB_EMITTER_A_CURRENT 8
`define MSB_EMITTER_B_CURRENT 7
`define LSB_EMITTER_B_CURRENT 0
`define FIXED_EMITTER_CURRENT 24'h010000

// drive, clock and power control fields
`define BIT_DRIVER_TOPOLOGY 11
`define BIT_OUTPUT_FLOAT 10
`define BIT_CRYSTAL_DISABLE 9
`define BIT_TX_POWERDOWN 2
`define BIT_RX_POWERDOWN 1
`define BIT_FRONTEND_POWERDOWN 0
`define FIXED_DRIVE_CLOCK_POWER 24'h020100

// clock control and fault pin fields
`define MSB_FAULT_CLOCK_SELECT 11
`define LSB_FAULT_CLOCK_SELECT 9
`define FIXED_CLOCK_CONTROL 24'h000002
`define BIT_FAULT_CLOCK_ROUTE 7

// sample selector codes
`define SEL_EMITTER_B 2'h0
`define SEL_EMITTER_B_AMBIENT 2'h1
`define SEL_EMITTER_A 2'h2
`define SEL_EMITTER_A_AMBIENT 2'h3

// fault pin timing source codes, 3'h5 and up route nothing
`define CLK_SEL_LAST 3'h4

`define RESET_CONTROL 24'h000000
`define RESET_SAMPLE 24'h000000

`endif

// ### tb/emitter_power_sample_regs_properties.sv
// concurrent checks on the register bank ports: read data timing,
// derived control outputs and the sample ready strobe.
// assumes the host port keeps the one-cycle strobe protocol.
`timescale 1ns/1ps
module emitter_power_sample_regs_properties
(
  input wire clk_sys,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [23:0] reg_rdata,
  input wire sample_valid,
  input wire conversion_ready_strobe,
  input wire led_drive_disable,
  input wire [7:0] emitter_a_current,
  input wire [7:0] emitter_b_current,
  input wire driver_topology_select,
  input wire crystal_osc_enable,
  input wire transmit_power_on,
  input wire receive_power_on,
  input wire diagnostic_power_on,
  input wire serial_data_out_oe,
  input wire clock_out_oe
);
  reg [23:0] wd1;
  reg [23:0] wd2;
  // write data delayed two edges, where the derived outputs land
  always @(posedge clk_sys)
  begin
    wd1 <= reg_wdata;
    wd2 <= wd1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_wr22;
    reg_write && reg_addr == 8'h22;
  endsequence
  sequence s_wr23;
    reg_write && reg_addr == 8'h23;
  endsequence
  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 24'h000000)
    else $error("read data not zero outside read cycle");
  a_strobe_cause: assert property (conversion_ready_strobe |-> $past(sample_valid))
    else $error("ready strobe without a sample");
  a_disable_follows: assert property (s_wr22 |-> ##2 led_drive_disable == wd2[17])
    else $error("drive disable does not follow write");
  a_codes_follow: assert property (
    s_wr22 |-> ##2 {emitter_a_current, emitter_b_current} == wd2[15:0])
    else $error("current codes do not follow write");
  a_topology_follows: assert property (s_wr23 |-> ##2 driver_topology_select == wd2[11])
    else $error("topology does not follow write");
  a_float_gates: assert property (
    s_wr23 |-> ##2 {serial_data_out_oe, clock_out_oe} == ~{wd2[10], wd2[10]})
    else $error("output enables do not follow float bit");
  a_crystal_follows: assert property (s_wr23 |-> ##2 crystal_osc_enable == !wd2[9])
    else $error("crystal enable does not follow write");
  a_power_follows: assert property (
    s_wr23 |-> ##2 {transmit_power_on, receive_power_on, diagnostic_power_on}
    == ~{wd2[2] | wd2[0], wd2[1] | wd2[0], wd2[0]})
    else $error("power outputs do not follow write");
endmodule // emitter_power_sample_regs_properties

bind emitter_power_sample_regs emitter_power_sample_regs_properties properties_i
(
  .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .sample_valid(sample_valid), .conversion_ready_strobe(conversion_ready_strobe),
  .led_drive_disable(led_drive_disable), .emitter_a_current(emitter_a_current),
  .emitter_b_current(emitter_b_current), .driver_topology_select(driver_topology_select),
  .crystal_osc_enable(crystal_osc_enable), .transmit_power_on(transmit_power_on),
  .receive_power_on(receive_power_on), .diagnostic_power_on(diagnostic_power_on),
  .serial_data_out_oe(serial_data_out_oe), .clock_out_oe(clock_out_oe)
);

// ### tb/converter_model.sv
// converter and timing source model: one result per request and
// counter bits as timing pulses for both fault pin sources.
// assumes requests arrive by non-blocking assignment on clk_sys.
`timescale 1ns/1ps
module converter_model
(
  input wire clk_sys,
  input wire req,
  input wire [1:0] sel,
  input wire [23:0] data,
  output reg sample_valid = 1'b0,
  output reg [1:0] sample_sel = 2'h0,
  output reg [23:0] sample_data = 24'h000000,
  output wire [4:0] timing_b,
  output wire [4:0] timing_a
);
  reg [4:0] cnt = 5'h00;
  assign timing_b = cnt;
  assign timing_a = ~cnt;
  // between results the bus toggles, so stale data can never pass
  always @(posedge clk_sys)
  begin
    cnt <= cnt + 5'h01;
    sample_valid <= req;
    sample_sel <= req ? sel : ~sample_sel;
    sample_data <= req ? data : ~sample_data;
  end
endmodule // converter_model

// ### tb/emitter_power_sample_regs_tb.sv
// self-checking bench for the emitter, power and sample register bank.
// assumes the converter model on the sample and timing inputs.
`timescale 1ns/1ps
module emitter_power_sample_regs_tb;
  localparam [23:0] FACT_A = 24'h3c3c3c; // arbitrary factory pattern
  localparam [23:0] FACT_B = 24'hc3c3c3; // arbitrary factory pattern
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [23:0] reg_wdata = 24'h000000;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg conv_req = 1'b0;
  reg [1:0] conv_sel = 2'h0;
  reg [23:0] conv_data = 24'h000000;
  reg photodiode_alarm = 1'b0;
  reg emitter_alarm = 1'b0;
  reg [4:0] prev_b = 5'h00;
  reg [4:0] prev_a = 5'h00;
  wire [23:0] reg_rdata;
  wire sample_valid;
  wire [1:0] sample_sel;
  wire [23:0] sample_data;
  wire [4:0] timing_b, timing_a;
  wire strobe, led_off, topo, xtal_on, tx_on, rx_on, dg_on;
  wire [7:0] cur_a, cur_b;
  wire pd_out, pd_oe, em_out, em_oe, sd_oe, ck_oe;
  wire [9:0] ctl = {led_off, topo, sd_oe, ck_oe, pd_oe, em_oe, xtal_on, tx_on, rx_on, dg_on};
  integer n_mismatch = 0;
  integer samples_checked = 0;
  integer i, b;

  emitter_power_sample_regs #(.FACTORY_A_VALUE(FACT_A), .FACTORY_B_VALUE(FACT_B))
    emitter_power_sample_regs_i
  (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_sel(sample_sel), .sample_data(sample_data),
    .conversion_ready_strobe(strobe), .timing_b(timing_b), .timing_a(timing_a),
    .photodiode_alarm(photodiode_alarm), .emitter_alarm(emitter_alarm),
    .led_drive_disable(led_off), .emitter_a_current(cur_a), .emitter_b_current(cur_b),
    .driver_topology_select(topo), .crystal_osc_enable(xtal_on),
    .transmit_power_on(tx_on), .receive_power_on(rx_on), .diagnostic_power_on(dg_on),
    .photodiode_fault_pin_out(pd_out), .photodiode_fault_pin_oe(pd_oe),
    .emitter_fault_pin_out(em_out), .emitter_fault_pin_oe(em_oe),
    .serial_data_out_oe(sd_oe), .clock_out_oe(ck_oe)
  );
  converter_model converter_model_i
  (
    .clk_sys(clk_sys), .req(conv_req), .sel(conv_sel), .data(conv_data),
    .sample_valid(sample_valid), .sample_sel(sample_sel), .sample_data(sample_data),
    .timing_b(timing_b), .timing_a(timing_a)
  );

  // free-running 250 MHz clock
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  // timing pulses as the design sampled them, for the one-cycle pin latency
  always @(posedge clk_sys)
  begin
    prev_b <= timing_b;
    prev_a <= timing_a;
  end

  task chk(input [23:0] seen, input [23:0] want);
    samples_checked = samples_checked + 1;
    if (seen !== want)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task settle;
    @(posedge clk_sys);
    #1;
  endtask
  task wr(input [7:0] a, input [23:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a, input [23:0] want);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, want);
  endtask
  task conv(input [1:0] s, input [23:0] d, input want);
    @(posedge clk_sys);
    conv_req <= 1'b1;
    conv_sel <= s;
    conv_data <= d;
    @(posedge clk_sys);
    conv_req <= 1'b0;
    settle;
    chk({23'h0, strobe}, {23'h0, want});
  endtask
  function [23:0] rst_val(input [7:0] a);
    case (a)
      8'h1e: rst_val = 24'h000002;
      8'h22: rst_val = 24'h010000;
      8'h23: rst_val = 24'h020100;
      8'h27: rst_val = FACT_A;
      8'h28: rst_val = FACT_B;
      default: rst_val = 24'h000000;
    endcase
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    settle;
    chk({14'h0, ctl}, 24'h0000ff);
    for (i = 8'h1e; i <= 8'h2e; i = i + 1)
      rd(i[7:0], rst_val(i[7:0]));
    // spares only ever get zeros from the host; the route register keeps its reset value
    for (i = 8'h24; i <= 8'h2e; i = i + 1)
      wr(i[7:0], (i < 8'h27 || i == 8'h29) ? 24'h000000 : 24'hffffff);
    for (i = 8'h24; i <= 8'h2e; i = i + 1)
      rd(i[7:0], rst_val(i[7:0]));
    $display("test reset and read-only done");
    wr(8'h22, 24'hfeab12);
    settle;
    chk({led_off, 7'h0, cur_a, cur_b}, 24'h80ab12);
    rd(8'h22, 24'h03ab12);
    wr(8'h22, 24'h000000);
    settle;
    chk({14'h0, ctl}, 24'h0000ff);
    for (i = 0; i < 6; i = i + 1)
    begin
      b = (i < 3) ? i : i + 6;
      wr(8'h23, 24'h000001 << b);
      settle;
      chk({14'h0, ctl}, {14'h0, 1'b0, b == 11, {4{b != 10}}, b != 9,
        b != 2 && b != 0, b != 1 && b != 0, b != 0});
    end
    wr(8'h23, 24'hffffff);
    rd(8'h23, 24'h020f07);
    wr(8'h23, 24'h000000);
    $display("test control fields done");
    for (i = 0; i < 4; i = i + 1)
    begin
      conv(i[1:0], 24'h5a0000 + i, 1'b1);
      rd(8'h2a + i[7:0], 24'h5a0000 + i);
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(8'h23, 24'h000001 << i);
      conv(2'h0, 24'h777777, 1'b0);
      rd(8'h2a, 24'h5a0000);
    end
    wr(8'h23, 24'h000000);
    $display("test samples done");
    @(posedge clk_sys);
    photodiode_alarm <= 1'b1;
    settle;
    chk({22'h0, pd_out, em_out}, 24'h000002);
    @(posedge clk_sys);
    photodiode_alarm <= 1'b0;
    emitter_alarm <= 1'b1;
    settle;
    chk({22'h0, pd_out, em_out}, 24'h000001);
    wr(8'h29, 24'hffffff);
    rd(8'h29, 24'h000080);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h1e, {21'h0, i[2:0]} << 9);
      settle;
      repeat (3)
      begin
        chk({22'h0, pd_out, em_out}, {22'h0, i < 5 ? prev_b[i] : 1'b0,
          i < 5 ? prev_a[i] : 1'b0});
        settle;
      end
      rd(8'h1e, 24'h000002 | ({21'h0, i[2:0]} << 9));
    end
    $display("test fault pins done");
    // port goes idle, so the host parks the digital outputs released
    wr(8'h23, 24'h000400);
    settle;
    chk({14'h0, ctl}, 24'h00000f);
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    settle;
    chk({14'h0, ctl}, 24'h0000ff);
    rd(8'h29, 24'h000000);
    rd(8'h2d, 24'h000000);
    $display("test second reset done");
    give_verdict;
  end

  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    #40000;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
endmodule // emitter_power_sample_regs_tb
